/* File: fpc_core_model.sv */
// fpc_core_model: integer-core side of the instruction bus and trap handshake
`default_nettype none
module fpc_core_model (
  input wire logic clk,
  input wire logic coproc_hold_n,
  input wire logic coproc_exception_n,
  output var logic [fpc_pkg::WORD_W-1:0] f_bus,
  output var logic instr_word_valid,
  output var logic instr_addr_valid,
  output var logic instr_last_cycle,
  output var logic flush,
  output var logic exception_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  bit ack_en = 1'b1;
  int ack_dly = 1;
  int wait_n = 0;
  // bus idle at time zero
  initial
  begin
    f_bus = '0;
    {instr_word_valid, instr_addr_valid, instr_last_cycle, flush} = '0;
  end
  // repeat the current cycle while the coprocessor holds
  task automatic held();
    logic h;
    do
    begin
      #1 h = coproc_hold_n;
      @(negedge clk);
    end
    while (h !== 1'b1);
  endtask
  // word, then address, then end cycle; fl flushes in the end cycle
  task automatic issue(input logic [31:0] w, input logic [31:0] a, input bit fl);
    @(negedge clk);
    f_bus = w;
    instr_word_valid = 1'b1;
    @(negedge clk);
    instr_word_valid = 1'b0;
    f_bus = a;
    instr_addr_valid = 1'b1;
    held();
    instr_addr_valid = 1'b0;
    f_bus = ~a; // released bus shows the inverse
    instr_last_cycle = 1'b1;
    flush = fl;
    held();
    instr_last_cycle = 1'b0;
    flush = 1'b0;
  endtask
  // trap taken some cycles after the exception, one-cycle acknowledge
  always @(negedge clk)
  begin
    wait_n = (coproc_exception_n === 1'b0 && ack_en) ? wait_n + 1 : 0;
    exception_ack = (wait_n > ack_dly);
  end
endmodule // fpc_core_model
`default_nettype wire

/* File: fpc_fifo.sv */
// fpc_fifo: floating-point instruction queue, valid/ready on both sides
`default_nettype none
module fpc_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic reset,
  fpc_q_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // honest full and empty flags
  assign q.in_ready = cnt_q != (AW+1)'(DEPTH);
  assign q.out_valid = cnt_q != '0;
  assign q.out_data = mem_q[rd_q];
  assign push = q.in_valid && q.in_ready;
  assign pop = q.out_valid && q.out_ready;

  // pointer and count update
  always_comb
  begin
    wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    else if (pop && !push)
      cnt_d = (AW+1)'(cnt_q - 1'b1);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem_q[wr_q] <= q.in_data;
  end
endmodule // fpc_fifo
`default_nettype wire

/* File: fpc_pkg.sv */
// fpc_pkg: constants and types for the fp coprocessor integer-core port
// Function
// - capture the instruction word when instr_word_valid is high
// - capture the instruction address in the write stage on instr_addr_valid
// - assert coproc_hold_n low in the write stage while a dependency exists
// - instr_last_cycle moves a pending fp-operate instruction into the queue; other pending instructions are dropped
// - flush discards the instruction registers, never the queue
// - condition code: 00 equal, 01 less, 10 greater, 11 unordered
// - cond_code_valid is low while any compare is pending
// - coproc_exception_n stays low until exception_ack is sampled high
// - coproc_present_n is held at ground
// - extended-precision instructions trap as unimplemented
// - nan or denormal operands end with the unfinished trap; compares trap unfinished on denormals only, moves never trap
// - state register bits 19:17 hold a read-only version field
// - register file 32x32, two reads and a write, plus load/store port
// - float-to-int rounds toward zero, int-to-float rounds per rd field
// - single moves copy, invert sign or clear sign
// - signalling compares trap when unordered, plain ones only set the code
// - reset clears the pipeline and writable state bits; hold it eight cycles
// - every stage begins on the rising clock edge
`default_nettype none
package fpc_pkg;
  localparam int WORD_W = 32;
  localparam int RF_WORDS = 32;
  localparam int RF_AW = 5;
  localparam int Q_DEPTH = 16;
  localparam int Q_W = 64;
  localparam int CNT_W = 5;
  localparam int RESET_MIN_CYCLES = 8;
  // instruction fields
  localparam int OP_LSB = 30;
  localparam int RD_LSB = 25;
  localparam int OP3_LSB = 19;
  localparam int RS1_LSB = 14;
  localparam int OPF_LSB = 5;
  localparam int RS2_LSB = 0;
  localparam logic [1:0] OP_ARITH = 2'h2;
  localparam logic [5:0] OP3_FPOP1 = 6'h34;
  localparam logic [5:0] OP3_FPOP2 = 6'h35;
  // operation codes
  localparam logic [8:0] OPF_FMOVS = 9'h001;
  localparam logic [8:0] OPF_FNEGS = 9'h005;
  localparam logic [8:0] OPF_FABSS = 9'h009;
  localparam logic [8:0] OPF_FITOS = 9'h0C4;
  localparam logic [8:0] OPF_FSTOI = 9'h0D1;
  localparam logic [8:0] OPF_FITOX = 9'h0C8;
  localparam logic [8:0] OPF_FSMULD = 9'h069;
  localparam logic [8:0] OPF_FDMULX = 9'h06E;
  localparam logic [4:0] OPF_CMP_HI = 5'h05;
  localparam logic [4:0] OPF_BIN_HI = 5'h04;
  // state register layout
  localparam int FSR_RD_LSB = 30;
  localparam int FSR_VER_LSB = 17;
  localparam int FSR_FTT_LSB = 14;
  localparam int FSR_FCC_LSB = 10;
  localparam logic [2:0] FSR_VERSION = 3'h5; // arbitrary value
  localparam logic [31:0] FSR_RESET = 32'h00000000;
  localparam logic [31:0] FSR_WR_MASK = 32'hFFF01FFF;
  localparam logic [2:0] FTT_IEEE = 3'h1;
  localparam logic [2:0] FTT_UNFIN = 3'h2;
  localparam logic [2:0] FTT_UNIMP = 3'h3;
  localparam logic [1:0] CC_EQ = 2'h0;
  localparam logic [1:0] CC_LT = 2'h1;
  localparam logic [1:0] CC_GT = 2'h2;
  localparam logic [1:0] CC_UN = 2'h3;
  localparam logic [1:0] RD_NEAR = 2'h0;
  localparam logic [1:0] RD_POS = 2'h2;
  localparam logic [1:0] RD_NEG = 2'h3;
  typedef enum logic [1:0] {EX_IDLE, EX_DP, EX_TRAP} fpc_exst_t;
endpackage
`default_nettype wire

/* File: fpc_port.sv */
// fpc_port: integer-core port, queue, control and small datapath of the fp coprocessor
`default_nettype none
module fpc_port (
  input wire logic clk,
  input wire logic ce,
  input wire logic reset,
  input wire logic [fpc_pkg::WORD_W-1:0] f_bus,
  input wire logic instr_word_valid,
  input wire logic instr_addr_valid,
  input wire logic instr_last_cycle,
  input wire logic flush,
  input wire logic exception_ack,
  output logic coproc_hold_n,
  output logic coproc_exception_n,
  output logic [1:0] fp_cond_code,
  output logic cond_code_valid,
  output logic coproc_present_n,
  output logic [fpc_pkg::WORD_W-1:0] exc_addr,
  input wire logic ls_wr_en,
  input wire logic [fpc_pkg::RF_AW-1:0] ls_addr,
  input wire logic [fpc_pkg::WORD_W-1:0] ls_wr_data,
  output logic [fpc_pkg::WORD_W-1:0] ls_rd_data,
  input wire logic fsr_wr_en,
  input wire logic [fpc_pkg::WORD_W-1:0] fsr_wr_data,
  output logic [fpc_pkg::WORD_W-1:0] fsr_value,
  output logic dp_start,
  output logic [8:0] dp_opf,
  output logic [fpc_pkg::WORD_W-1:0] dp_a,
  output logic [fpc_pkg::WORD_W-1:0] dp_b,
  input wire logic dp_done,
  input wire logic [fpc_pkg::WORD_W-1:0] dp_result
);
  import fpc_pkg::*;

  // decode helpers
  function automatic logic is_fp_operate_instr(input logic [31:0] i);
    return i[OP_LSB +: 2] == OP_ARITH &&
      (i[OP3_LSB +: 6] == OP3_FPOP1 || i[OP3_LSB +: 6] == OP3_FPOP2);
  endfunction
  function automatic logic is_cmp(input logic [8:0] o);
    return o[8:4] == OPF_CMP_HI;
  endfunction
  function automatic logic is_ext(input logic [8:0] o);
    return o[1:0] == 2'h3 || o[3:2] == 2'h3 || o == OPF_FITOX ||
      o == OPF_FSMULD || o == OPF_FDMULX;
  endfunction
  function automatic logic is_nan(input logic [31:0] x);
    return x[30:23] == 8'hFF && x[22:0] != '0;
  endfunction
  function automatic logic is_dn(input logic [31:0] x);
    return x[30:23] == 8'h00 && x[22:0] != '0;
  endfunction
  // single compare, ordered key on sign-magnitude
  function automatic logic [1:0] cmp_single(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] ka, kb;
    ka = a[31] ? ~a : (a | 32'h80000000);
    kb = b[31] ? ~b : (b | 32'h80000000);
    if (is_nan(a) || is_nan(b))
      return CC_UN;
    else if ((a[30:0] == '0 && b[30:0] == '0) || ka == kb)
      return CC_EQ;
    else if (ka < kb)
      return CC_LT;
    return CC_GT;
  endfunction
  // float to int, truncating toward zero, saturating
  function automatic logic [31:0] to_int(input logic [31:0] x);
    logic [31:0] m;
    logic [7:0] e;
    e = x[30:23];
    m = {8'h00, 1'b1, x[22:0]};
    if (e < 8'd127)
      return '0;
    if (e > 8'd157)
      return x[31] ? 32'h80000000 : 32'h7FFFFFFF;
    m = (e >= 8'd150) ? (m << (e - 8'd150)) : (m >> (8'd150 - e));
    return x[31] ? 32'(-m) : m;
  endfunction
  // int to float, rounded per the rounding field
  function automatic logic [31:0] to_float(input logic [31:0] i, input logic [1:0] rd);
    logic [31:0] mag, kept, rem, half;
    logic [4:0] p, sh;
    logic s, inc;
    logic [7:0] e;
    s = i[31];
    mag = s ? 32'(-i) : i;
    p = '0;
    for (int k = 0; k < 32; k++)
      if (mag[k])
        p = 5'(k);
    if (mag == '0)
      return '0;
    e = 8'(8'd127 + p);
    if (p <= 5'd23)
      return {s, e, 23'((mag << (5'd23 - p)))};
    sh = 5'(p - 5'd23);
    kept = mag >> sh;
    rem = mag & ((32'h1 << sh) - 32'h1);
    half = 32'h1 << (sh - 5'd1);
    case (rd)
      RD_NEAR: inc = rem > half || (rem == half && kept[0]);
      RD_POS: inc = rem != '0 && !s;
      RD_NEG: inc = rem != '0 && s;
      default: inc = 1'b0;
    endcase
    kept = 32'(kept + {31'h0, inc});
    if (kept[24])
      return {s, 8'(e + 8'd1), 23'h0};
    return {s, e, kept[22:0]};
  endfunction

  fpc_q_if #(.W(Q_W)) qi ();
  fpc_fifo #(.W(Q_W), .DEPTH(Q_DEPTH)) u_queue (
    .clk(clk),
    .ce(ce),
    .reset(reset),
    .q(qi)
  );

  // front end: instruction register and write-stage pending slot
  logic [31:0] ins_q, ins_d, padr_q, padr_d, pins_q, pins_d;
  logic ins_v_q, ins_v_d, pend_v_q, pend_v_d;
  logic w_stage, pend_leaves, dep, end_go;

  assign end_go = pend_v_q && instr_last_cycle && !flush;
  assign pend_leaves = end_go && (qi.in_ready || !is_fp_operate_instr(pins_q));
  assign qi.in_valid = end_go && is_fp_operate_instr(pins_q);
  assign qi.in_data = {padr_q, pins_q};
  assign w_stage = instr_addr_valid && ins_v_q;
  // resource dependency: slot still busy or queue full
  assign dep = (w_stage && ((pend_v_q && !pend_leaves) || !qi.in_ready)) ||
    (pend_v_q && !qi.in_ready);
  assign coproc_hold_n = !dep;
  assign coproc_present_n = 1'b0;

  always_comb
  begin
    ins_d = ins_q;
    ins_v_d = ins_v_q;
    pins_d = pins_q;
    padr_d = padr_q;
    pend_v_d = pend_v_q;
    if (pend_leaves)
      pend_v_d = 1'b0;
    if (w_stage && !dep)
    begin
      pins_d = ins_q;
      padr_d = f_bus;
      pend_v_d = 1'b1;
      ins_v_d = 1'b0;
    end
    if (instr_word_valid)
    begin
      ins_d = f_bus;
      ins_v_d = 1'b1;
    end
    if (flush)
    begin
      ins_v_d = 1'b0;
      pend_v_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ins_q <= '0;
      ins_v_q <= 1'b0;
      pins_q <= '0;
      padr_q <= '0;
      pend_v_q <= 1'b0;
    end
    else if (ce)
    begin
      ins_q <= ins_d;
      ins_v_q <= ins_v_d;
      pins_q <= pins_d;
      padr_q <= padr_d;
      pend_v_q <= pend_v_d;
    end
  end

  // register file, 32 x 32 (pairs form 16 x 64)
  logic [31:0] rf_q [RF_WORDS];
  logic rf_we;
  logic [RF_AW-1:0] rf_wa;
  logic [31:0] rf_wd, ra, rb;
  logic [31:0] pins;
  logic [8:0] popf;
  assign pins = qi.out_data[31:0];
  assign popf = pins[OPF_LSB +: 9];
  assign ra = rf_q[pins[RS1_LSB +: RF_AW]];
  assign rb = rf_q[pins[RS2_LSB +: RF_AW]];

  // arithmetic write wins over a load to the same word
  always_ff @(posedge clk)
  begin
    if (ce && rf_we)
      rf_q[rf_wa] <= rf_wd;
    if (ce && ls_wr_en && !(rf_we && rf_wa == ls_addr))
      rf_q[ls_addr] <= ls_wr_data;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      ls_rd_data <= '0;
    else if (ce)
      ls_rd_data <= rf_q[ls_addr];
  end

  // executor, state register, exception and compare tracking
  fpc_exst_t st_q, st_d;
  logic [4:0] crd_q, crd_d;
  logic [31:0] fsr_q, fsr_d, xad_d, dpa_d, dpb_d;
  logic [8:0] dpo_d;
  logic exc_q, exc_d, dps_d, ccv_d, go_trap, cmp_done;
  logic [2:0] ftt_new;
  logic [1:0] cc;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  assign qi.out_ready = st_q == EX_IDLE;
  assign coproc_exception_n = !exc_q;
  assign fp_cond_code = fsr_q[FSR_FCC_LSB +: 2];
  assign fsr_value = {fsr_q[31:20], FSR_VERSION, fsr_q[16:0]};

  always_comb
  begin
    st_d = st_q;
    crd_d = crd_q;
    fsr_d = fsr_q;
    exc_d = exc_q;
    xad_d = exc_addr;
    dps_d = 1'b0;
    dpo_d = dp_opf;
    dpa_d = dp_a;
    dpb_d = dp_b;
    rf_we = 1'b0;
    rf_wa = pins[RD_LSB +: RF_AW];
    rf_wd = '0;
    go_trap = 1'b0;
    ftt_new = '0;
    cmp_done = 1'b0;
    cc = cmp_single(ra, rb);
    if (fsr_wr_en)
      fsr_d = (fsr_wr_data & FSR_WR_MASK) | (fsr_q & ~FSR_WR_MASK);
    case (st_q)
      EX_IDLE:
        if (qi.out_valid)
        begin
          crd_d = pins[RD_LSB +: RF_AW];
          if (is_ext(popf))
          begin
            go_trap = 1'b1;
            ftt_new = FTT_UNIMP;
          end
          else if (popf == OPF_FMOVS || popf == OPF_FNEGS || popf == OPF_FABSS)
          begin
            rf_we = 1'b1;
            rf_wd = {popf == OPF_FNEGS ? !rb[31] : (popf == OPF_FMOVS && rb[31]), rb[30:0]};
          end
          else if (popf == OPF_FITOS)
          begin
            rf_we = 1'b1;
            rf_wd = to_float(rb, fsr_q[FSR_RD_LSB +: 2]);
          end
          else if (is_cmp(popf))
          begin
            cmp_done = 1'b1;
            if (is_dn(ra) || is_dn(rb))
            begin
              go_trap = 1'b1;
              ftt_new = FTT_UNFIN;
            end
            else if (cc == CC_UN && popf[2])
            begin
              go_trap = 1'b1;
              ftt_new = FTT_IEEE;
            end
            else
              fsr_d[FSR_FCC_LSB +: 2] = cc;
          end
          else if (is_nan(rb) || is_dn(rb) ||
            (popf[8:4] == OPF_BIN_HI && (is_nan(ra) || is_dn(ra))))
          begin
            go_trap = 1'b1;
            ftt_new = FTT_UNFIN;
          end
          else if (popf == OPF_FSTOI)
          begin
            rf_we = 1'b1;
            rf_wd = to_int(rb);
          end
          else
          begin
            dps_d = 1'b1;
            dpo_d = popf;
            dpa_d = ra;
            dpb_d = rb;
            st_d = EX_DP;
          end
          if (go_trap)
          begin
            st_d = EX_TRAP;
            exc_d = 1'b1;
            xad_d = qi.out_data[63:32];
            fsr_d[FSR_FTT_LSB +: 3] = ftt_new;
          end
        end
      EX_DP:
        if (dp_done)
        begin
          rf_we = 1'b1;
          rf_wa = crd_q;
          rf_wd = dp_result;
          st_d = EX_IDLE;
        end
      EX_TRAP:
        if (exception_ack)
        begin
          exc_d = 1'b0;
          st_d = EX_IDLE;
        end
      default:
        st_d = EX_IDLE;
    endcase
    // pending compares: queued plus executing
    cnt_d = cnt_q;
    if (qi.in_valid && qi.in_ready && is_cmp(pins_q[OPF_LSB +: 9]))
      cnt_d = CNT_W'(cnt_d + 1'b1);
    if (cmp_done)
      cnt_d = CNT_W'(cnt_d - 1'b1);
    ccv_d = cnt_d == '0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_q <= EX_IDLE;
      crd_q <= '0;
      fsr_q <= FSR_RESET;
      exc_q <= 1'b0;
      exc_addr <= '0;
      dp_start <= 1'b0;
      dp_opf <= '0;
      dp_a <= '0;
      dp_b <= '0;
      cnt_q <= '0;
      cond_code_valid <= 1'b1;
    end
    else if (ce)
    begin
      st_q <= st_d;
      crd_q <= crd_d;
      fsr_q <= fsr_d;
      exc_q <= exc_d;
      exc_addr <= xad_d;
      dp_start <= dps_d;
      dp_opf <= dpo_d;
      dp_a <= dpa_d;
      dp_b <= dpb_d;
      cnt_q <= cnt_d;
      cond_code_valid <= ccv_d;
    end
  end
endmodule // fpc_port
`default_nettype wire

/* File: fpc_port_props.sv */
// fpc_port_props: concurrent checks on the fp coprocessor port outputs
`default_nettype none
module fpc_port_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic exception_ack,
  input wire logic fsr_wr_en,
  input wire logic [fpc_pkg::WORD_W-1:0] fsr_wr_data,
  input wire logic coproc_exception_n,
  input wire logic [1:0] fp_cond_code,
  input wire logic cond_code_valid,
  input wire logic coproc_present_n,
  input wire logic [fpc_pkg::WORD_W-1:0] fsr_value
);
  import fpc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // exception waiting for, and receiving, its acknowledge
  sequence s_exc_wait;
    !coproc_exception_n && !exception_ack;
  endsequence
  sequence s_exc_taken;
    !coproc_exception_n && exception_ack;
  endsequence
  a_exc_held: assert property (s_exc_wait |=> !coproc_exception_n)
    else $error("exception dropped before acknowledge");
  a_exc_release: assert property (s_exc_taken |=> coproc_exception_n)
    else $error("exception kept after acknowledge");
  a_exc_cause: assert property ($rose(coproc_exception_n) |-> $past(exception_ack))
    else $error("exception released without acknowledge");
  a_present_gnd: assert property (coproc_present_n == 1'b0)
    else $error("present line not low");
  a_version_ro: assert property (fsr_value[FSR_VER_LSB+:3] == FSR_VERSION)
    else $error("version field changed");
  a_fcc_in_fsr: assert property (fp_cond_code == fsr_value[FSR_FCC_LSB+:2])
    else $error("condition code differs from state register");
  a_fcc_after_cmp: assert property ($changed(fp_cond_code) && !$past(fsr_wr_en)
    |-> !$past(cond_code_valid))
    else $error("condition code changed while marked valid");
  a_reset_out: assert property ($fell(reset)
    |-> coproc_exception_n && cond_code_valid && fp_cond_code == CC_EQ)
    else $error("outputs not cleared by reset");
  a_fsr_load: assert property (fsr_wr_en
    |=> ((fsr_value ^ $past(fsr_wr_data)) & 32'hFFF00000) == 32'h0)
    else $error("state register load lost");
endmodule // fpc_port_props
bind fpc_port fpc_port_props u_props (.clk(clk), .reset(reset), .exception_ack(exception_ack),
  .fsr_wr_en(fsr_wr_en), .fsr_wr_data(fsr_wr_data), .coproc_exception_n(coproc_exception_n),
  .fp_cond_code(fp_cond_code), .cond_code_valid(cond_code_valid),
  .coproc_present_n(coproc_present_n), .fsr_value(fsr_value));
`default_nettype wire

/* File: fpc_q_if.sv */
// fpc_q_if: valid/ready carrier between the port logic and its queue
`default_nettype none
interface fpc_q_if #(parameter int W = 64);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

/* File: tb_fpc_port.sv */
// tb_fpc_port: self-checking bench for the fp coprocessor integer-core port
`default_nettype none
module tb_fpc_port;
  timeunit 1ns;
  timeprecision 1ns;
  import fpc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ls_wr_en = 1'b0, fsr_wr_en = 1'b0, dp_done = 1'b0, hold_seen = 1'b0, ce = 1'b1;
  logic [4:0] ls_addr = '0;
  logic [31:0] ls_wr_data = '0, fsr_wr_data = '0, dp_result = '0, adr = '0;
  logic [31:0] f_bus, exc_addr, ls_rd_data, fsr_value, dp_a, dp_b;
  logic instr_word_valid, instr_addr_valid, instr_last_cycle, flush, exception_ack;
  logic coproc_hold_n, coproc_exception_n, cond_code_valid, coproc_present_n, dp_start;
  logic [1:0] fp_cond_code;
  logic [8:0] dp_opf, last_opf;
  logic [31:0] rf_m [32];
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  localparam logic [8:0] MV [3] = '{OPF_FMOVS, OPF_FNEGS, OPF_FABSS};
  localparam logic [31:0] XR [3] = '{32'h0, 32'h80000000, 32'h0};
  localparam logic [31:0] AN [3] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h7FFFFFFF};
  localparam logic [4:0] R1 [4] = '{5'd11, 5'd12, 5'd11, 5'd11};
  localparam logic [4:0] R2 [4] = '{5'd12, 5'd11, 5'd11, 5'd13};
  localparam logic [1:0] CC [4] = '{CC_LT, CC_GT, CC_EQ, CC_UN};
  localparam logic [1:0] RM [3] = '{RD_NEAR, RD_POS, RD_NEG};
  localparam logic [31:0] FI [3] = '{32'h4B800000, 32'h4B800001, 32'h4B800000};
  always #50 clk = ~clk;
  fpc_core_model core (.clk, .coproc_hold_n, .coproc_exception_n, .f_bus, .instr_word_valid,
    .instr_addr_valid, .instr_last_cycle, .flush, .exception_ack);
  fpc_port DUT (.clk, .ce, .reset, .f_bus, .instr_word_valid, .instr_addr_valid,
    .instr_last_cycle, .flush, .exception_ack, .coproc_hold_n, .coproc_exception_n,
    .fp_cond_code, .cond_code_valid, .coproc_present_n, .exc_addr, .ls_wr_en, .ls_addr,
    .ls_wr_data, .ls_rd_data, .fsr_wr_en, .fsr_wr_data, .fsr_value, .dp_start, .dp_opf,
    .dp_a, .dp_b, .dp_done, .dp_result);
  // datapath stub: answers a ^ b two cycles after start
  always @(negedge clk)
    if (dp_start === 1'b1)
    begin
      last_opf = dp_opf;
      repeat (2) @(negedge clk);
      dp_result = dp_a ^ dp_b;
      dp_done = 1'b1;
      @(negedge clk);
      dp_done = 1'b0;
    end
  // hold monitor and hang limit
  always @(negedge clk)
  begin
    hold_seen = hold_seen | (coproc_hold_n === 1'b0);
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] mk(input logic [5:0] op3, input logic [4:0] rd, rs1,
      input logic [8:0] opf, input logic [4:0] rs2);
    return {OP_ARITH, rd, op3, rs1, opf, rs2};
  endfunction
  // load port write and store port readback against the model
  task automatic rf_write(input logic [4:0] a, input logic [31:0] d);
    @(negedge clk);
    ls_addr = a;
    ls_wr_data = d;
    ls_wr_en = 1'b1;
    @(negedge clk);
    ls_wr_en = 1'b0;
    rf_m[a] = d;
  endtask
  task automatic rf_check(input logic [4:0] a);
    @(negedge clk);
    ls_addr = a;
    @(negedge clk);
    check(ls_rd_data, rf_m[a]);
  endtask
  task automatic fsr_load(input logic [31:0] d);
    @(negedge clk);
    fsr_wr_data = d;
    fsr_wr_en = 1'b1;
    @(negedge clk);
    fsr_wr_en = 1'b0;
  endtask
  task automatic run(input logic [31:0] w);
    adr = $urandom;
    core.issue(w, adr, 1'b0);
    repeat (8) @(negedge clk);
  endtask
  task automatic trap(input logic [31:0] w, input logic [2:0] ftt);
    core.ack_en = 1'b0;
    run(w);
    check(coproc_exception_n, 0);
    check(fsr_value[FSR_FTT_LSB+:3], ftt);
    check(exc_addr, adr);
  endtask
  task automatic ack_go();
    core.ack_en = 1'b1;
    repeat (4) @(negedge clk);
    check(coproc_exception_n, 1);
  endtask
  task automatic cmp(input logic [31:0] w, input logic [1:0] exp);
    core.issue(w, $urandom, 1'b0);
    check(cond_code_valid, 0);
    for (int n = 0; n < 10 && cond_code_valid !== 1'b1; n++)
      @(negedge clk);
    check(cond_code_valid, 1);
    check(fp_cond_code, exp);
  endtask
  task automatic rst_chk();
    reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check({coproc_hold_n, coproc_exception_n, cond_code_valid, coproc_present_n}, 4'hE);
    check(fsr_value, {12'h0, FSR_VERSION, 17'h0});
  endtask
  // main sequence
  initial
  begin
    void'($urandom(20447));
    rst_chk();
    rf_write(1, ($urandom & 32'h807FFFFF) | 32'h3F000000);
    foreach (MV[i])
    begin
      run(mk(OP3_FPOP1, 5'(8 + i), 5'd0, MV[i], 5'd1));
      rf_m[8 + i] = (rf_m[1] ^ XR[i]) & AN[i];
      rf_check(5'(8 + i));
    end
    // clock enable low freezes the load port write
    ce = 1'b0;
    rf_write(9, ~rf_m[9]);
    rf_m[9] = ~rf_m[9];
    ce = 1'b1;
    rf_check(9);
    rf_write(11, 32'h3F800000);
    rf_write(12, 32'h40000000);
    rf_write(13, 32'h7FC00000);
    for (int i = 0; i < 7; i++)
      cmp(mk(OP3_FPOP2, 5'd0, R1[i % 4], {OPF_CMP_HI, i < 4 ? 4'h1 : 4'h5}, R2[i % 4]), CC[i % 4]);
    trap(mk(OP3_FPOP2, 5'd0, 5'd11, {OPF_CMP_HI, 4'h5}, 5'd13), FTT_IEEE);
    ack_go();
    check(fp_cond_code, CC_EQ);
    rf_write(4, 32'h00000001);
    trap(mk(OP3_FPOP1, 5'd19, 5'd0, OPF_FSTOI, 5'd4), FTT_UNFIN);
    ack_go();
    trap(mk(OP3_FPOP2, 5'd0, 5'd4, {OPF_CMP_HI, 4'h1}, 5'd11), FTT_UNFIN);
    ack_go();
    rf_write(5, 32'h40300000);
    rf_write(6, 32'hC0300000);
    run(mk(OP3_FPOP1, 5'd14, 5'd0, OPF_FSTOI, 5'd5));
    run(mk(OP3_FPOP1, 5'd15, 5'd0, OPF_FSTOI, 5'd6));
    rf_m[14] = 32'h2;
    rf_m[15] = 32'hFFFFFFFE;
    rf_check(14);
    rf_check(15);
    rf_write(7, 32'h01000001);
    foreach (RM[i])
    begin
      fsr_load({RM[i], 30'h0});
      run(mk(OP3_FPOP1, 5'd16, 5'd0, OPF_FITOS, 5'd7));
      rf_m[16] = FI[i];
      rf_check(16);
    end
    run(mk(OP3_FPOP1, 5'd17, 5'd1, 9'h041, 5'd5));
    rf_m[17] = rf_m[1] ^ rf_m[5];
    check(last_opf, 9'h041);
    rf_check(17);
    // flushed in its end cycle, then reissued
    rf_write(18, $urandom);
    core.issue(mk(OP3_FPOP1, 5'd18, 5'd0, OPF_FNEGS, 5'd1), 32'h0, 1'b1);
    repeat (8) @(negedge clk);
    rf_check(18);
    run(mk(OP3_FPOP1, 5'd18, 5'd0, OPF_FNEGS, 5'd1));
    rf_m[18] = rf_m[1] ^ 32'h80000000;
    rf_check(18);
    // queue frozen behind a trap fills until hold, then drains
    trap(mk(OP3_FPOP1, 5'd2, 5'd0, OPF_FITOX, 5'd1), FTT_UNIMP);
    fork
      for (int k = 0; k < 18; k++)
        core.issue(mk(OP3_FPOP1, 5'(k + 14), 5'd0, OPF_FABSS, 5'd1), 32'h0, 1'b0);
      begin
        repeat (100) @(negedge clk);
        check(hold_seen, 1);
        check(coproc_exception_n, 0);
        core.ack_en = 1'b1;
      end
    join
    repeat (30) @(negedge clk);
    for (int k = 14; k < 32; k++)
    begin
      rf_m[k] = rf_m[1] & 32'h7FFFFFFF;
      rf_check(5'(k));
    end
    rst_chk();
    summarize();
  end
endmodule // tb_fpc_port
`default_nettype wire
